// *** hw/lcg_pkg.sv ***
// Purpose: shared constants and types of the lite clock source generator
// Assumes: 20 MHz control clock, 32-bit register port
// Notes:   register offsets are byte addresses of aligned words
package lcg_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTL_ONE  = 8'h00; // clkgen_control_one
  localparam logic [7:0] OFS_CTL_TWO  = 8'h04; // clkgen_control_two
  localparam logic [7:0] OFS_STATUS   = 8'h08; // clkgen_status, read only
  localparam logic [7:0] OFS_STAT_CTL = 8'h0c; // clkgen_status_control
  localparam logic [7:0] OFS_MISC     = 8'h10; // miscellaneous control
  localparam logic [7:0] OFS_USB_TRIM = 8'h14; // usb recovery control / trim
  localparam logic [7:0] OFS_IDENT    = 8'h18; // block identity
  // field positions
  localparam int CTL1_SRC_LSB   = 6;  // [7:6] source select
  localparam int CTL1_SLOW_EN   = 1;  // slow_osc_enable
  localparam int CTL1_STOP_KEEP = 0;  // ref_stop_keep_enable
  localparam int CTL2_RANGE_8M  = 0;  // 1 = 8 MHz, 0 = 2 MHz
  localparam int CTL2_EXT_LSB   = 4;  // [5:4] external range
  localparam int ST_MODE_LSB    = 2;  // [3:2] mode in effect
  localparam int ST_BUSY        = 4;  // switch in progress
  localparam int ST_EXT_OK      = 5;  // external clock present
  localparam int ST_REFUSED     = 6;  // sticky: request refused
  localparam int ST_FAST_RUN    = 7;  // fast oscillator running
  localparam int SC_REF_CLR     = 0;  // write 1 clears refused flag
  localparam int SC_DIV1_LSB    = 1;  // [3:1] first ref divider
  localparam int MISC_FAST_EN   = 7;  // fast_osc_enable
  localparam int MISC_DIV2_LSB  = 0;  // [2:0] ref_out_second_divider
  localparam int USB_REC_EN     = 0;  // usb clock recovery enable
  localparam int USB_TRIM_LSB   = 8;  // [15:8] fine trim readback
  // source select codes and reset values
  localparam logic [1:0] SRC_FAST  = 2'b00;
  localparam logic [1:0] SRC_SLOW  = 2'b01;
  localparam logic [1:0] SRC_EXT   = 2'b10;
  localparam logic [1:0] RST_SRC   = SRC_SLOW;
  localparam logic       RST_8M    = 1'b1;
  localparam logic [7:0] RST_TRIM  = 8'h80;
  localparam logic [31:0] IDENT_VALUE = 32'h0000_1c6e; // arbitrary value
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SETTLE_TIME_NS = 3000; // fast oscillator start, longest
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  (SETTLE_TIME_NS / CLK_PERIOD_NS);
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_FAST  = 2'b00,
    MODE_SLOW8 = 2'b01,
    MODE_SLOW2 = 2'b11,
    MODE_EXT   = 2'b10
  } lcg_mode_t;
  typedef enum logic [1:0] {
    PWR_RUN, PWR_VERY_LOW_POWER_RUN, PWR_STOP, PWR_LEAK
  } lcg_pwr_t;
endpackage

// *** hw/lcg_trim_if.sv ***
// Purpose: carrier between control logic and the fine trim unit
// Assumes: single clock domain
// Notes:   inc/dec are one-cycle pulses from usb logic
`timescale 1ns/10ps
interface lcg_trim_if;
  logic       enable; // recovery active
  logic       inc;    // raise trim one step
  logic       dec;    // lower trim one step
  logic [7:0] trim;   // current fine trim
  modport ctl (output enable, output inc, output dec, input trim);
  modport trm (input enable, input inc, input dec, output trim);
endinterface

// *** hw/lcg_div.sv ***
// Purpose: power-of-two tick divider for the internal reference path
// Assumes: tick_in is a one-cycle pulse on clk
// Notes:   exponent 0 passes ticks through
`timescale 1ns/10ps
module lcg_div #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] exp_sel,
  output logic              tick_out
);
  import lcg_pkg::*;
  localparam int CW = (1 << W);
  initial begin
    if (W < 1 || W > 4) $error("lcg_div: W out of range");
  end
  logic [CW-1:0] cnt_reg;  // running tick count
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;
  logic [CW-1:0] mask;     // low bits that must all be one
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    mask     = CW'((CW'(1) << exp_sel) - CW'(1));
    cnt_next = cnt_reg;
    out_next = 1'b0;
    if (tick_in) begin
      // wrap at the selected power of two
      if ((cnt_reg & mask) == mask) begin
        cnt_next = '0;
        out_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end
  assign tick_out = out_reg;
endmodule

// *** hw/lcg_trim.sv ***
// Purpose: fine trim value of the fast oscillator under usb recovery
// Assumes: steps arrive from usb logic on clk
// Notes:   saturates at both ends, holds when recovery is off
`timescale 1ns/10ps
module lcg_trim (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  lcg_trim_if.trm   tif
);
  import lcg_pkg::*;
  logic [7:0] trim_reg;  // fine trim
  logic [7:0] trim_next;
  // ----------------------------------------
  // step logic
  // ----------------------------------------
  always_comb begin
    trim_next = trim_reg;
    if (tif.enable && tif.inc && trim_reg != 8'hff) begin
      trim_next = trim_reg + 8'h01;
    end else if (tif.enable && tif.dec && trim_reg != 8'h00) begin
      trim_next = trim_reg - 8'h01;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trim_reg <= RST_TRIM;
    end else if (ce) begin
      trim_reg <= trim_next;
    end
  end
  assign tif.trim = trim_reg;
endmodule

// *** hw/lcg_top.sv ***
// Purpose: lite clock source generator control, four modes, no loops
// Assumes: power state and usb steps come from logic on clk
// Notes:   outputs steer the analog oscillators and the clock muxes
// Operation
// - four modes: fast 48M, slow 8M, slow 2M, external
// - reset brings up slow 8 MHz mode
// - no direct switch between 2M and 8M
// - very low power run blocks the range-change sequence
// - generator fully off in low-leakage stops
// - fast oscillator never runs in low power
// - slow oscillator usable in all non-leakage low power
// - source select field picks output clock
// - slow enable bit turns slow oscillator on
// - stop keep bit holds reference in stop
// - fast enable runs 48M oscillator when unselected
// - second divider only on reference output path
// - usb recovery steps fast oscillator fine trim
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module lcg_top #(
  parameter int DIV_W = 3
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  input  wire lcg_pkg::lcg_pwr_t pwr_state,
  input  wire logic              ext_clk_ok,
  input  wire logic              slow_osc_tick,
  input  wire logic              usb_fs_device,
  input  wire logic              usb_trim_inc,
  input  wire logic              usb_trim_dec,
  output lcg_pkg::lcg_mode_t     active_mode,
  output logic                   fast_osc_on,
  output logic                   slow_osc_on,
  output logic                   slow_osc_8m,
  output logic                   ref_clk_tick,
  output logic                   generator_off,
  output logic [7:0]             fast_fine_trim
);
  import lcg_pkg::*;
  initial begin
    if (DIV_W < 1 || DIV_W > 3) $error("lcg_top: DIV_W out of range");
  end
  typedef enum logic {ST_RUN, ST_SETTLE} lcg_state_t;
  localparam int SCW = $clog2(SETTLE_CYCLES + 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // mode requested by the select field and the slow range bit
  function automatic lcg_mode_t req_mode(input logic [1:0] src, input logic r8);
    unique case (src)
      SRC_FAST: req_mode = MODE_FAST;
      SRC_SLOW: req_mode = r8 ? MODE_SLOW8 : MODE_SLOW2;
      default:  req_mode = MODE_EXT;
    endcase
  endfunction
  function automatic logic is_slow(input lcg_mode_t m);
    is_slow = (m == MODE_SLOW8) || (m == MODE_SLOW2);
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic ext_meta_reg;  // first stage, read only by second
  logic ext_sync_reg;  // safe copy of the external clock good pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else if (ce) begin
      ext_meta_reg <= ext_clk_ok;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0]       src_reg, src_next;             // source select
  logic             slow_en_reg, slow_en_next;     // slow_osc_enable
  logic             keep_reg, keep_next;           // ref_stop_keep_enable
  logic             r8_reg, r8_next;               // slow range 8 MHz
  logic [1:0]       erange_reg, erange_next;       // external range
  logic [DIV_W-1:0] div1_reg, div1_next;           // first ref divider
  logic [DIV_W-1:0] div2_reg, div2_next;           // ref_out_second_divider
  logic             fast_en_reg, fast_en_next;     // fast_osc_enable
  logic             usb_en_reg, usb_en_next;       // usb recovery request
  logic             refused_reg, refused_next;     // sticky refused flag
  logic [31:0]      rdata_reg, rdata_next;         // read data, one cycle late
  lcg_mode_t        mode_reg, mode_next;           // mode in effect
  lcg_mode_t        last_slow_reg, last_slow_next; // last slow range used
  lcg_state_t       st_reg, st_next;               // switch sequencer
  logic [SCW-1:0]   cnt_reg, cnt_next;             // settle counter
  logic             fast_on_reg, fast_on_next;
  logic             slow_on_reg, slow_on_next;
  logic             off_reg, off_next;
  logic             low_power;                     // any low-power state
  lcg_mode_t        want;                          // requested mode
  logic             refuse;                        // request not allowed
  logic [31:0]      st_word;                       // status read word
  lcg_trim_if       tif ();                        // carrier to the trim unit, read by the port logic

  assign low_power = (pwr_state != PWR_RUN);

  // ----------------------------------------
  // register writes and reads
  // ----------------------------------------
  always_comb begin
    src_next     = src_reg;
    slow_en_next = slow_en_reg;
    keep_next    = keep_reg;
    r8_next      = r8_reg;
    erange_next  = erange_reg;
    div1_next    = div1_reg;
    div2_next    = div2_reg;
    fast_en_next = fast_en_reg;
    usb_en_next  = usb_en_reg;
    rdata_next   = 32'h0000_0000;
    st_word      = 32'h0000_0000;
    st_word[ST_MODE_LSB +: 2] = mode_reg;
    st_word[ST_BUSY]          = (st_reg == ST_SETTLE);
    st_word[ST_EXT_OK]        = ext_sync_reg;
    st_word[ST_REFUSED]       = refused_reg;
    st_word[ST_FAST_RUN]      = fast_on_reg;
    if (wr) begin
      unique case (addr)
        OFS_CTL_ONE: begin
          src_next     = wdata[CTL1_SRC_LSB +: 2];
          slow_en_next = wdata[CTL1_SLOW_EN];
          keep_next    = wdata[CTL1_STOP_KEEP];
        end
        OFS_CTL_TWO: begin
          r8_next     = wdata[CTL2_RANGE_8M];
          erange_next = wdata[CTL2_EXT_LSB +: 2];
        end
        OFS_STAT_CTL: div1_next = wdata[SC_DIV1_LSB +: DIV_W];
        OFS_MISC: begin
          fast_en_next = wdata[MISC_FAST_EN];
          div2_next    = wdata[MISC_DIV2_LSB +: DIV_W];
        end
        OFS_USB_TRIM: usb_en_next = wdata[USB_REC_EN];
        default: ;                                  // unmapped: ignored
      endcase
    end
    if (rd) begin
      unique case (addr)
        OFS_CTL_ONE: begin
          rdata_next[CTL1_SRC_LSB +: 2] = src_reg;
          rdata_next[CTL1_SLOW_EN]      = slow_en_reg;
          rdata_next[CTL1_STOP_KEEP]    = keep_reg;
        end
        OFS_CTL_TWO: begin
          rdata_next[CTL2_RANGE_8M]     = r8_reg;
          rdata_next[CTL2_EXT_LSB +: 2] = erange_reg;
        end
        OFS_STATUS:   rdata_next = st_word;
        OFS_STAT_CTL: rdata_next[SC_DIV1_LSB +: DIV_W] = div1_reg;
        OFS_MISC: begin
          rdata_next[MISC_FAST_EN]           = fast_en_reg;
          rdata_next[MISC_DIV2_LSB +: DIV_W] = div2_reg;
        end
        OFS_USB_TRIM: begin
          rdata_next[USB_REC_EN]        = usb_en_reg;
          rdata_next[USB_TRIM_LSB +: 8] = tif.trim;
        end
        OFS_IDENT: rdata_next = IDENT_VALUE;
        default:   rdata_next = 32'h0000_0000;     // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_reg     <= RST_SRC;
      slow_en_reg <= 1'b0;
      keep_reg    <= 1'b0;
      r8_reg      <= RST_8M;
      erange_reg  <= 2'b00;
      div1_reg    <= '0;
      div2_reg    <= '0;
      fast_en_reg <= 1'b0;
      usb_en_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end else if (ce) begin
      src_reg     <= src_next;
      slow_en_reg <= slow_en_next;
      keep_reg    <= keep_next;
      r8_reg      <= r8_next;
      erange_reg  <= erange_next;
      div1_reg    <= div1_next;
      div2_reg    <= div2_next;
      fast_en_reg <= fast_en_next;
      usb_en_reg  <= usb_en_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ----------------------------------------
  // mode switch sequencer
  // ----------------------------------------
  // a refused request leaves the old mode running; software sees it
  // through the sticky flag and the mode field never moving
  always_comb begin
    want   = req_mode(src_reg, r8_reg);
    refuse = 1'b0;
    if (is_slow(want) && is_slow(mode_reg) && want != mode_reg) begin
      refuse = 1'b1;
    end
    if (pwr_state == PWR_VERY_LOW_POWER_RUN && is_slow(want) && want != last_slow_reg) begin
      refuse = 1'b1;
    end
    if (low_power && want == MODE_FAST) begin
      refuse = 1'b1;
    end
    if (want == MODE_EXT && !ext_sync_reg) begin
      refuse = 1'b1;
    end
    st_next        = st_reg;
    cnt_next       = cnt_reg;
    mode_next      = mode_reg;
    last_slow_next = last_slow_reg;
    refused_next   = refused_reg;
    // clear by write one; a new refusal in the same cycle wins
    if (wr && addr == OFS_STAT_CTL && wdata[SC_REF_CLR]) begin
      refused_next = 1'b0;
    end
    if (pwr_state != PWR_LEAK) begin
      unique case (st_reg)
        ST_RUN: begin
          if (want != mode_reg) begin
            if (refuse) begin
              refused_next = 1'b1;
            end else if (want == MODE_FAST && !fast_on_reg) begin
              st_next  = ST_SETTLE;                 // wait for start-up
              cnt_next = SCW'(SETTLE_CYCLES);
            end else begin
              mode_next = want;
            end
          end
        end
        ST_SETTLE: begin
          if (want != MODE_FAST || low_power) begin
            st_next = ST_RUN;                       // request withdrawn or low power entered
          end else if (cnt_reg == SCW'(1)) begin
            st_next   = ST_RUN;
            mode_next = MODE_FAST;
          end else begin
            cnt_next = cnt_reg - SCW'(1);
          end
        end
      endcase
    end
    if (is_slow(mode_next)) begin
      last_slow_next = mode_next;
    end
  end

  // ----------------------------------------
  // oscillator enables
  // ----------------------------------------
  always_comb begin
    off_next     = (pwr_state == PWR_LEAK);
    fast_on_next = 1'b0;
    slow_on_next = 1'b0;
    if (!off_next) begin
      // fast runs when selected, starting, or forced, but not in low power
      fast_on_next = !low_power &&
                     (fast_en_reg || mode_reg == MODE_FAST ||
                      st_reg == ST_SETTLE);
      // slow runs when it clocks the system or feeds the reference
      slow_on_next = is_slow(mode_reg) ||
                     (slow_en_reg && (pwr_state != PWR_STOP || keep_reg));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg        <= ST_RUN;
      cnt_reg       <= '0;
      mode_reg      <= MODE_SLOW8;
      last_slow_reg <= MODE_SLOW8;
      refused_reg   <= 1'b0;
      fast_on_reg   <= 1'b0;
      slow_on_reg   <= 1'b1;
      off_reg       <= 1'b0;
    end else if (ce) begin
      st_reg        <= st_next;
      cnt_reg       <= cnt_next;
      mode_reg      <= mode_next;
      last_slow_reg <= last_slow_next;
      refused_reg   <= refused_next;
      fast_on_reg   <= fast_on_next;
      slow_on_reg   <= slow_on_next;
      off_reg       <= off_next;
    end
  end

  // ----------------------------------------
  // reference output dividers
  // ----------------------------------------
  // the main clock path never passes these dividers
  logic ref_gate;   // slow ticks allowed onto the reference path
  logic div1_tick;  // after first divider
  logic ref_tick;   // after second divider
  assign ref_gate = slow_on_reg && slow_en_reg && slow_osc_tick;
  lcg_div #(.W(DIV_W)) u_div1 (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .tick_in  (ref_gate),
    .exp_sel  (div1_reg),
    .tick_out (div1_tick)
  );
  lcg_div #(.W(DIV_W)) u_div2 (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .tick_in  (div1_tick),
    .exp_sel  (div2_reg),
    .tick_out (ref_tick)
  );

  // ----------------------------------------
  // usb clock recovery trim
  // ----------------------------------------
  // steps only count while the fast oscillator runs for a full speed device
  assign tif.enable = usb_en_reg && usb_fs_device && fast_on_reg;
  assign tif.inc    = usb_trim_inc;
  assign tif.dec    = usb_trim_dec;
  lcg_trim u_trim (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .tif   (tif)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic [7:0] trim_out_reg;  // registered copy of the fine trim
  logic       tick_out_reg;  // registered reference tick
  logic       slow8_out_reg; // registered slow range, so the pin has no gate after the flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trim_out_reg  <= RST_TRIM;
      tick_out_reg  <= 1'b0;
      slow8_out_reg <= RST_8M;
    end else if (ce) begin
      trim_out_reg  <= tif.trim;
      slow8_out_reg <= (last_slow_next == MODE_SLOW8);
      tick_out_reg <= ref_tick && !off_reg;
    end
  end
  assign rdata          = rdata_reg;
  assign active_mode    = mode_reg;
  assign fast_osc_on    = fast_on_reg;
  assign slow_osc_on    = slow_on_reg;
  assign slow_osc_8m    = slow8_out_reg;
  assign ref_clk_tick   = tick_out_reg;
  assign generator_off  = off_reg;
  assign fast_fine_trim = trim_out_reg;
endmodule

// *** dv/lcg_top_assertions.sv ***
// Purpose: port-level assertions for the lite clock generator
// Assumes: ce is held high, one clock domain
// Notes:   bound into lcg_top below
`timescale 1ns/10ps
module lcg_top_chk
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [7:0]        addr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  input wire lcg_pkg::lcg_pwr_t pwr_state,
  input wire logic              slow_osc_tick,
  input wire logic              usb_fs_device,
  input wire lcg_pkg::lcg_mode_t active_mode,
  input wire logic              fast_osc_on,
  input wire logic              slow_osc_on,
  input wire logic              slow_osc_8m,
  input wire logic              ref_clk_tick,
  input wire logic              generator_off,
  input wire logic [7:0]        fast_fine_trim
);
  import lcg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  reset_mode_a: assert property ($past(reset) |-> active_mode == MODE_SLOW8 && slow_osc_on && !fast_osc_on)
    else $error("mode after reset wrong");
  // the two slow ranges share one circuit, so no hop between them
  no_slow_hop_a: assert property ($changed(active_mode) |->
    !({$past(active_mode), active_mode} inside {4'b0111, 4'b1101}))
    else $error("direct slow range hop");
  very_low_power_run_range_a: assert property (pwr_state == PWR_VERY_LOW_POWER_RUN ##1 pwr_state == PWR_VERY_LOW_POWER_RUN |-> $stable(slow_osc_8m))
    else $error("range changed in very low power run");
  leak_off_a: assert property (pwr_state == PWR_LEAK |=> generator_off && !fast_osc_on && !slow_osc_on)
    else $error("generator not off in leakage stop");
  fast_low_power_a: assert property (pwr_state != PWR_RUN |-> ##[1:2] !fast_osc_on)
    else $error("fast oscillator on in low power");
  ref_tick_cause_a: assert property (ref_clk_tick |-> $past(slow_osc_tick, 3))
    else $error("reference tick without source tick");
  trim_hold_a: assert property (!usb_fs_device [*3] |-> $stable(fast_fine_trim))
    else $error("trim moved without full speed device");
  status_mode_a: assert property (rd && addr == OFS_STATUS |=> rdata[3:2] == $past(active_mode))
    else $error("status mode differs from active mode");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  ext_cov: cover property (active_mode == MODE_EXT);
  slow2_cov: cover property (active_mode == MODE_SLOW2);
  leak_cov: cover property (generator_off);
  ref_cov: cover property (ref_clk_tick);
endmodule
bind lcg_top lcg_top_chk u_chk (.*);

// *** dv/tb_lcg_top.sv ***
// Purpose: directed bench for the lite clock generator
// Assumes: ce tied high, 20 MHz clock
// Notes:   waits after writes follow the two-edge switch latency
`timescale 1ns/10ps
module tb_lcg_top;
  import lcg_pkg::*;
  logic       clk, reset, ce, wr, rd, ext_clk_ok, slow_osc_tick;
  logic       usb_fs_device, usb_trim_inc, usb_trim_dec;
  logic       fast_osc_on, slow_osc_on, slow_osc_8m, ref_clk_tick, generator_off;
  logic [7:0] addr, fast_fine_trim;
  logic [31:0] wdata, rdata;
  lcg_pwr_t   pwr_state;
  lcg_mode_t  active_mode;
  int         err_total, total_checks, cycles, refs;
  lcg_top DUT (.clk, .reset, .ce, .addr, .wdata, .wr, .rd, .rdata, .pwr_state, .ext_clk_ok,
    .slow_osc_tick, .usb_fs_device, .usb_trim_inc, .usb_trim_dec, .active_mode, .fast_osc_on,
    .slow_osc_on, .slow_osc_8m, .ref_clk_tick, .generator_off, .fast_fine_trim);
  // ----------------------------------------
  // clock, timeout, tick counter
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (ref_clk_tick === 1'b1) refs++;
    if (cycles == 6000) begin
      err_total++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task give_verdict;
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    cyc(3);
  endtask
  // read data stand only in the cycle after the strobe
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  task ticks(input int n);
    refs = 0;
    repeat (n) begin
      @(posedge clk);
      slow_osc_tick <= 1'b1;
      @(posedge clk);
      slow_osc_tick <= 1'b0;
      cyc(3);
    end
    cyc(4);
  endtask
  task step(input logic up);
    @(posedge clk);
    usb_trim_inc <= up;
    usb_trim_dec <= !up;
    @(posedge clk);
    usb_trim_inc <= 1'b0;
    usb_trim_dec <= 1'b0;
    cyc(3);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {wr, rd, ext_clk_ok, slow_osc_tick, usb_fs_device, usb_trim_inc, usb_trim_dec} = '0;
    {addr, wdata, err_total, total_checks, cycles, refs} = '0;
    reset = 1'b1;
    ce = 1'b1;
    pwr_state = PWR_RUN;
    cyc(16);
    reset <= 1'b0;
    cyc(1);
    chk(active_mode, MODE_SLOW8);
    chk({slow_osc_on, fast_osc_on, fast_fine_trim}, {2'b10, RST_TRIM});
    rchk(OFS_IDENT, '1, IDENT_VALUE);
    rchk(8'h1c, '1, 32'h0);
    wreg(OFS_CTL_TWO, 32'h0);
    chk(active_mode, MODE_SLOW8);
    rchk(OFS_STATUS, 32'h40, 32'h40);
    wreg(OFS_CTL_TWO, 32'h1);
    wreg(OFS_STAT_CTL, 32'h1);
    rchk(OFS_STATUS, 32'h40, 32'h0);
    wreg(OFS_CTL_ONE, 32'h82);
    chk(active_mode, MODE_SLOW8);
    ext_clk_ok <= 1'b1;
    cyc(6);
    chk(active_mode, MODE_EXT);
    rchk(OFS_STATUS, 32'h2c, 32'h28);
    wreg(OFS_CTL_TWO, 32'h0);
    wreg(OFS_CTL_ONE, 32'h42);
    chk({active_mode, slow_osc_8m}, {MODE_SLOW2, 1'b0});
    rchk(OFS_STATUS, 32'h0c, 32'h0c);
    wreg(OFS_MISC, 32'h80);
    chk({active_mode, fast_osc_on}, {MODE_SLOW2, 1'b1});
    wreg(OFS_CTL_ONE, 32'h02);
    chk(active_mode, MODE_FAST);
    wreg(OFS_CTL_ONE, 32'h42);
    pwr_state <= PWR_VERY_LOW_POWER_RUN;
    cyc(3);
    chk({fast_osc_on, slow_osc_on}, 2'b01);
    wreg(OFS_CTL_TWO, 32'h1);
    chk(active_mode, MODE_SLOW2);
    wreg(OFS_CTL_TWO, 32'h0);
    pwr_state <= PWR_LEAK;
    cyc(3);
    chk({generator_off, slow_osc_on, fast_osc_on}, 3'b100);
    pwr_state <= PWR_RUN;
    cyc(3);
    chk(generator_off, 1'b0);
    ticks(4);
    chk(refs, 4);
    wreg(OFS_MISC, 32'h81);
    ticks(4);
    chk(refs, 2);
    wreg(OFS_CTL_ONE, 32'h40);
    ticks(4);
    chk({refs[7:0], active_mode}, {8'h0, MODE_SLOW2});
    wreg(OFS_USB_TRIM, 32'h1);
    usb_fs_device <= 1'b1;
    step(1'b1);
    chk(fast_fine_trim, 8'h81);
    step(1'b0);
    step(1'b0);
    rchk(OFS_USB_TRIM, 32'hff00, 32'h7f00);
    usb_fs_device <= 1'b0;
    step(1'b1);
    chk(fast_fine_trim, 8'h7f);
    wreg(OFS_MISC, 32'h0);
    chk(fast_osc_on, 1'b0);
    wreg(OFS_CTL_ONE, 32'h0);
    rchk(OFS_STATUS, 32'h1c, 32'h1c);
    cyc(60);
    chk(active_mode, MODE_FAST);
    give_verdict();
  end
endmodule
